// ### sample_convert_pkg.sv
// Constants, timing counts and state encodings for the sample conversion control.
// Assumes a single 25 MHz clock shared with the processor timing pulses.
// ----------------------------------------------------------------------------
// Behaviour
// - Thirty-two channels, one selected per sample.
// - Channel loaded from instruction at fourth pulse, delayed fifth pulse in fast mode.
// - Set busy, then settle five microseconds.
// - Settle end sets hold, one microsecond wait.
// - Wait end issues one conversion start pulse.
// - Recycle enable needs sample, and pause in regular mode or busy in fast.
// - Pause release sets stall; fifth pulses hold.
// - Each stalled fifth pulse loads converter into accumulator.
// - Low nine converter bits inverted, ones complement.
// - Magnitude low nine bits, top bit extends sign.
// - Done clears busy, hold and pause flags.
// - Release order: sync, stall flag, leave state.
// - Regular sample takes about nineteen microseconds.
// - Preset sets pause; pause restored after sample.
// - Special function with select bit sets fast.
// - Fast: old result first, new conversion delayed.
// - Fast and idle: no recycle, processor continues.
// - Fast while busy: stall, load, then restart.
// ----------------------------------------------------------------------------
package sample_convert_pkg;

    // ------------------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------------------
    localparam int CHANNEL_W = 5;
    localparam int CONV_W    = 10;
    localparam int ACC_W     = 12;
    localparam int TIMER_W   = 8;
    localparam int MAG_W     = 9;
    localparam int SIGN_W    = 3;

    // ------------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------------
    localparam int CLOCK_PERIOD_NS = 40;
    localparam int SETTLE_NS       = 5000;
    localparam int HOLD_NS         = 1000;
    localparam int SAMPLE_TOTAL_NS = 19000;
    localparam int FAST_SPACING_NS = 18200;
    localparam int FAST_EXEC_NS    = 1600;

    // Least times round up to whole cycles.
    localparam logic [TIMER_W-1:0] SETTLE_CYCLES =
        TIMER_W'((SETTLE_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS);
    localparam logic [TIMER_W-1:0] HOLD_CYCLES =
        TIMER_W'((HOLD_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS);

    // ------------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------------
    localparam logic [CHANNEL_W-1:0] CHANNEL_RESET = 5'h00;
    localparam logic [ACC_W-1:0]     ACC_RESET     = 12'h000;
    localparam logic [CONV_W-1:0]    CONV_RESET    = 10'h000;
    localparam logic [TIMER_W-1:0]   TIMER_RESET   = 8'h00;
    localparam logic [TIMER_W-1:0]   TIMER_LAST    = 8'h01;
    localparam logic                 PAUSE_RESET   = 1'b1;

    // ------------------------------------------------------------------------
    // Conversion sequencer states, Gray along idle-settle-stable-convert
    // ------------------------------------------------------------------------
    typedef enum logic [1:0] {
        SEQ_IDLE    = 2'h0,
        SEQ_SETTLE  = 2'h1,
        SEQ_STABLE  = 2'h3,
        SEQ_CONVERT = 2'h2
    } seq_state_e;

endpackage : sample_convert_pkg

// ### interval_timer.sv
// One-shot down counter that times the settling and stabilisation intervals.
// Assumes the loader waits for expiry before loading again.
module interval_timer
    import sample_convert_pkg::*;
(
    input  wire logic               clock,
    input  wire logic               arst_n,
    input  wire logic               load,
    input  wire logic [TIMER_W-1:0] load_value,
    output      logic               expired
);

    // ------------------------------------------------------------------------
    // Counter
    // ------------------------------------------------------------------------
    logic [TIMER_W-1:0] count_q;
    logic [TIMER_W-1:0] count_d;

    // The last count is flagged combinationally so the interval lasts exactly
    // load_value cycles from the loading edge to the next state change.
    assign expired = (count_q == TIMER_LAST);

    always_comb begin
        count_d = count_q;
        if (load) begin
            count_d = load_value;
        end else if (count_q != TIMER_RESET) begin
            count_d = count_q - TIMER_LAST;
        end
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            count_q <= TIMER_RESET;
        end else begin
            count_q <= count_d;
        end
    end

endmodule : interval_timer

// ### sample_convert_control.sv
// Conversion control: channel select, settle and hold timing, start pulse,
// processor stall in the fifth time state and accumulator result delivery.
// Assumes timing pulses and instruction decode come from logic on the same
// clock; the converter's done line and data are asynchronous pins.
module sample_convert_control
    import sample_convert_pkg::*;
(
    input  wire logic                 clock,
    input  wire logic                 arst_n,
    input  wire logic                 io_preset,
    input  wire logic                 sample_instruction,
    input  wire logic                 special_function_instruction,
    input  wire logic                 fast_mode_select_bit,
    input  wire logic [CHANNEL_W-1:0] instruction_channel,
    input  wire logic                 fourth_timing_pulse,
    input  wire logic                 fifth_timing_pulse,
    input  wire logic                 delayed_fifth_pulse,
    input  wire logic                 pause_release_pulse,
    input  wire logic                 conversion_done,
    input  wire logic [CONV_W-1:0]    converter_data,
    output      logic [CHANNEL_W-1:0] channel_select_register,
    output      logic                 conversion_busy_flag,
    output      logic                 sample_hold_flag,
    output      logic                 conversion_start_pulse,
    output      logic                 sample_pause_flag,
    output      logic                 sample_recycle_enable,
    output      logic                 recycle_sync_flag,
    output      logic                 state_five_recycle_flag,
    output      logic                 fifth_time_state,
    output      logic                 early_readout_mode_flag,
    output      logic                 accumulator_load,
    output      logic [ACC_W-1:0]     accumulator_data
);

    localparam int SETTLE_LO = SETTLE_CYCLES;
    localparam int HOLD_LO   = HOLD_CYCLES;

    // ------------------------------------------------------------------------
    // Converter pin synchronisers
    // ------------------------------------------------------------------------
    logic              done_meta_q;
    logic              done_sync_q;
    logic              done_prev_q;
    logic [CONV_W-1:0] conv_meta_q;
    logic [CONV_W-1:0] conv_sync_q;
    logic              done_rise;

    // Data is only sampled well after it settles, so a plain two-stage
    // per-bit synchroniser is enough here.
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            done_meta_q <= 1'b0;
            done_sync_q <= 1'b0;
            done_prev_q <= 1'b0;
            conv_meta_q <= CONV_RESET;
            conv_sync_q <= CONV_RESET;
        end else begin
            done_meta_q <= conversion_done;
            done_sync_q <= done_meta_q;
            done_prev_q <= done_sync_q;
            conv_meta_q <= converter_data;
            conv_sync_q <= conv_meta_q;
        end
    end

    assign done_rise = done_sync_q & ~done_prev_q;

    // ------------------------------------------------------------------------
    // Processor handshake flags
    // ------------------------------------------------------------------------
    logic recycle_en;
    logic regular_start;
    logic fast_start;
    logic seq_start;
    logic fast_d;
    logic pause_d;
    logic sync_d;
    logic t5_recycle_d;
    logic ts5_d;
    logic recycle_en_d;

    // Fast mode only stalls when a conversion is still running.
    assign recycle_en = sample_instruction &
                        ((sample_pause_flag & ~early_readout_mode_flag) |
                         (early_readout_mode_flag & conversion_busy_flag));

    assign regular_start = fourth_timing_pulse & sample_instruction &
                           sample_pause_flag & ~early_readout_mode_flag &
                           ~conversion_busy_flag;
    // Blocking the fast start while the stall flag stands keeps a finished
    // conversion from being restarted before its result is read.
    assign fast_start = delayed_fifth_pulse & sample_instruction &
                        early_readout_mode_flag & ~conversion_busy_flag &
                        ~state_five_recycle_flag;
    assign seq_start = regular_start | fast_start;

    always_comb begin
        fast_d       = early_readout_mode_flag;
        pause_d      = sample_pause_flag;
        sync_d       = recycle_sync_flag;
        t5_recycle_d = state_five_recycle_flag;
        ts5_d        = fifth_time_state;
        recycle_en_d = recycle_en;
        if (special_function_instruction) begin
            fast_d = fast_mode_select_bit;
        end
        if (io_preset) begin
            fast_d = 1'b0;
        end
        if (done_rise) begin
            pause_d = 1'b0;
        end
        if (fifth_timing_pulse) begin
            if (state_five_recycle_flag) begin
                ts5_d = 1'b1;
            end else if (fifth_time_state) begin
                ts5_d   = 1'b0;
                pause_d = 1'b1;
            end
            if (!recycle_en) begin
                sync_d = 1'b0;
            end
        end
        if (fourth_timing_pulse && recycle_en) begin
            sync_d = 1'b1;
        end
        if (pause_release_pulse) begin
            t5_recycle_d = recycle_sync_flag;
        end
        if (io_preset) begin
            pause_d = 1'b1;
        end
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            early_readout_mode_flag <= 1'b0;
            sample_pause_flag       <= PAUSE_RESET;
            recycle_sync_flag       <= 1'b0;
            state_five_recycle_flag <= 1'b0;
            fifth_time_state        <= 1'b0;
            sample_recycle_enable   <= 1'b0;
        end else begin
            early_readout_mode_flag <= fast_d;
            sample_pause_flag       <= pause_d;
            recycle_sync_flag       <= sync_d;
            state_five_recycle_flag <= t5_recycle_d;
            fifth_time_state        <= ts5_d;
            sample_recycle_enable   <= recycle_en_d;
        end
    end

    // ------------------------------------------------------------------------
    // Conversion sequencer
    // ------------------------------------------------------------------------
    seq_state_e           seq_q;
    seq_state_e           seq_d;
    logic [CHANNEL_W-1:0] channel_d;
    logic                 busy_d;
    logic                 hold_d;
    logic                 start_d;
    logic                 timer_load;
    logic [TIMER_W-1:0]   timer_value;
    logic                 timer_expired;

    interval_timer u_interval_timer (
        .clock      (clock),
        .arst_n     (arst_n),
        .load       (timer_load),
        .load_value (timer_value),
        .expired    (timer_expired)
    );

    // Total sample time is the two intervals plus the converter's own time,
    // about nineteen microseconds with the converter it is built for.
    always_comb begin
        seq_d       = seq_q;
        channel_d   = channel_select_register;
        busy_d      = conversion_busy_flag;
        hold_d      = sample_hold_flag;
        start_d     = 1'b0;
        timer_load  = 1'b0;
        timer_value = SETTLE_CYCLES;
        case (seq_q)
            SEQ_IDLE: begin
                if (seq_start) begin
                    channel_d  = instruction_channel;
                    busy_d     = 1'b1;
                    timer_load = 1'b1;
                    seq_d      = SEQ_SETTLE;
                end
            end
            SEQ_SETTLE: begin
                if (timer_expired) begin
                    hold_d      = 1'b1;
                    timer_load  = 1'b1;
                    timer_value = HOLD_CYCLES;
                    seq_d       = SEQ_STABLE;
                end
            end
            SEQ_STABLE: begin
                if (timer_expired) begin
                    start_d = 1'b1;
                    seq_d   = SEQ_CONVERT;
                end
            end
            SEQ_CONVERT: begin
                if (done_rise) begin
                    seq_d = SEQ_IDLE;
                end
            end
            default: begin
                seq_d = SEQ_IDLE;
            end
        endcase
        if (done_rise) begin
            busy_d = 1'b0;
            hold_d = 1'b0;
        end
        if (io_preset) begin
            seq_d  = SEQ_IDLE;
            busy_d = 1'b0;
            hold_d = 1'b0;
        end
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            seq_q                   <= SEQ_IDLE;
            channel_select_register <= CHANNEL_RESET;
            conversion_busy_flag    <= 1'b0;
            sample_hold_flag        <= 1'b0;
            conversion_start_pulse  <= 1'b0;
        end else begin
            seq_q                   <= seq_d;
            channel_select_register <= channel_d;
            conversion_busy_flag    <= busy_d;
            sample_hold_flag        <= hold_d;
            conversion_start_pulse  <= start_d;
        end
    end

    // ------------------------------------------------------------------------
    // Accumulator result
    // ------------------------------------------------------------------------
    logic             acc_load_d;
    logic [ACC_W-1:0] acc_data_d;

    // Every fifth pulse of a sample loads the live converter word; in fast
    // mode that is the previous conversion, read before the restart.
    always_comb begin
        acc_load_d = fifth_timing_pulse & sample_instruction;
        acc_data_d = accumulator_data;
        if (acc_load_d) begin
            acc_data_d = {{SIGN_W{conv_sync_q[CONV_W-1]}},
                          ~conv_sync_q[MAG_W-1:0]};
        end
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            accumulator_load <= 1'b0;
            accumulator_data <= ACC_RESET;
        end else begin
            accumulator_load <= acc_load_d;
            accumulator_data <= acc_data_d;
        end
    end

    // ------------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------------
    settle_to_hold_a: assert property (@(posedge clock) disable iff (!arst_n)
        $rose(conversion_busy_flag) |-> ##[SETTLE_LO:SETTLE_LO]
            (sample_hold_flag || !conversion_busy_flag))
        else $error("Hold flag did not follow the settling interval.");

    hold_to_start_a: assert property (@(posedge clock) disable iff (!arst_n)
        $rose(sample_hold_flag) && !io_preset |-> ##[HOLD_LO:HOLD_LO]
            (conversion_start_pulse || !sample_hold_flag))
        else $error("Start pulse did not follow the hold interval.");

    start_single_a: assert property (@(posedge clock) disable iff (!arst_n)
        conversion_start_pulse |=> !conversion_start_pulse && sample_hold_flag)
        else $error("Start pulse longer than one cycle or without hold.");

    done_clears_a: assert property (@(posedge clock) disable iff (!arst_n)
        done_rise && !io_preset && !fifth_timing_pulse |=>
            !conversion_busy_flag && !sample_hold_flag && !sample_pause_flag)
        else $error("Done did not clear busy, hold and pause.");

    sync_set_a: assert property (@(posedge clock) disable iff (!arst_n)
        fourth_timing_pulse && recycle_en |=> recycle_sync_flag && sample_recycle_enable)
        else $error("Recycle sync not set at the fourth pulse.");

    ts5_stall_a: assert property (@(posedge clock) disable iff (!arst_n)
        fifth_timing_pulse && state_five_recycle_flag |=> fifth_time_state)
        else $error("Fifth time state not held while stalled.");

    acc_format_a: assert property (@(posedge clock) disable iff (!arst_n)
        accumulator_load |-> accumulator_data[MAG_W-1:0] == ~$past(conv_sync_q[MAG_W-1:0])
            && accumulator_data[ACC_W-1:MAG_W] == {SIGN_W{$past(conv_sync_q[CONV_W-1])}})
        else $error("Accumulator word not formed from converter code.");

    fast_flag_a: assert property (@(posedge clock) disable iff (!arst_n)
        special_function_instruction && !io_preset |=>
            early_readout_mode_flag == $past(fast_mode_select_bit))
        else $error("Fast mode flag not loaded from select bit.");

    pause_preset_a: assert property (@(posedge clock) disable iff (!arst_n)
        io_preset |=> sample_pause_flag && !early_readout_mode_flag)
        else $error("Preset did not set pause and clear fast mode.");

    fast_idle_a: assert property (@(posedge clock) disable iff (!arst_n)
        fourth_timing_pulse && early_readout_mode_flag && !conversion_busy_flag
            && !recycle_sync_flag |=> !recycle_sync_flag)
        else $error("Fast sample recycled with no conversion busy.");

endmodule : sample_convert_control

// ### far_side_model.sv
// Far side of the sample conversion control: processor timing pulses and converter.
// Assumes the bench gives the code that the next conversion will return.
module far_side_model
    import sample_convert_pkg::*;
#(
    parameter int CONV_CYCLES = 300
)(
    input  wire logic              clock,
    input  wire logic              arst_n,
    input  wire logic              conversion_start_pulse,
    input  wire logic [CONV_W-1:0] next_code,
    output      logic              fourth_timing_pulse,
    output      logic              fifth_timing_pulse,
    output      logic              delayed_fifth_pulse,
    output      logic              pause_release_pulse,
    output      logic              conversion_done,
    output      logic [CONV_W-1:0] converter_data
);
    // ------------------------------------------------------------------------
    // Pulses repeat every eight cycles; the converter keeps its last code.
    // ------------------------------------------------------------------------
    logic [2:0]        phase_q;
    int                count_q;
    logic [CONV_W-1:0] code_q;

    assign pause_release_pulse = (phase_q == 3'h1);
    assign fourth_timing_pulse = (phase_q == 3'h3);
    assign fifth_timing_pulse  = (phase_q == 3'h4);
    assign delayed_fifth_pulse = (phase_q == 3'h5);
    // Done is held four cycles so that the two-flop synchroniser cannot miss it.
    assign conversion_done     = (count_q != 0) && (count_q <= 4);

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            phase_q        <= 3'h0;
            count_q        <= 0;
            code_q         <= 10'h000;
            converter_data <= 10'h000;
        end else begin
            phase_q <= phase_q + 3'h1;
            if (conversion_start_pulse) begin
                count_q <= CONV_CYCLES;
                code_q  <= next_code;
            end else if (count_q != 0) begin
                count_q <= count_q - 1;
            end
            if (count_q == 5) begin
                converter_data <= code_q;
            end
        end
    end
endmodule : far_side_model

// ### testbench.sv
// Self-checking bench for the sample conversion control, random and corner cases.
// Assumes the far side model supplies timing pulses and converter answers.
module testbench import sample_convert_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    // ------------------------------------------------------------------------
    // Signals, helpers and monitors
    // ------------------------------------------------------------------------
    logic clock, arst_n, io_preset, sample_instruction, special_function_instruction;
    logic fast_mode_select_bit, fourth_timing_pulse, fifth_timing_pulse, delayed_fifth_pulse;
    logic pause_release_pulse, conversion_done, conversion_busy_flag, sample_hold_flag;
    logic conversion_start_pulse, sample_pause_flag, sample_recycle_enable, recycle_sync_flag;
    logic state_five_recycle_flag, fifth_time_state, early_readout_mode_flag, accumulator_load;
    logic [CHANNEL_W-1:0] instruction_channel, channel_select_register;
    logic [CONV_W-1:0]    converter_data, next_code, c;
    logic [ACC_W-1:0]     accumulator_data;
    logic                 stalled, recycled;
    int                   fail_count = 0, check_count = 0, settle_n = 0, hold_n = 0, seed = 35;
    logic [CONV_W-1:0]    corner [4] = '{10'h000, 10'h1FF, 10'h200, 10'h3FF};
    int                   span_n = 0, loads = 0;

    sample_convert_control dut (.clock, .arst_n, .io_preset, .sample_instruction,
        .special_function_instruction, .fast_mode_select_bit, .instruction_channel,
        .fourth_timing_pulse, .fifth_timing_pulse, .delayed_fifth_pulse, .pause_release_pulse,
        .conversion_done, .converter_data, .channel_select_register, .conversion_busy_flag,
        .sample_hold_flag, .conversion_start_pulse, .sample_pause_flag, .sample_recycle_enable,
        .recycle_sync_flag, .state_five_recycle_flag, .fifth_time_state,
        .early_readout_mode_flag, .accumulator_load, .accumulator_data);
    far_side_model model (.clock, .arst_n, .conversion_start_pulse, .next_code,
        .fourth_timing_pulse, .fifth_timing_pulse, .delayed_fifth_pulse, .pause_release_pulse,
        .conversion_done, .converter_data);

    function automatic logic [ACC_W-1:0] to_acc(input logic [CONV_W-1:0] v);
        return {{SIGN_W{v[CONV_W-1]}}, ~v[MAG_W-1:0]};
    endfunction : to_acc

    task automatic chk(input string nm, input logic [ACC_W-1:0] e, input logic [ACC_W-1:0] g);
        check_count++;
        if (e !== g) begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task automatic close_out();
        $display("checks %0d failures %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : close_out

    // The instruction ends at a delayed pulse once every stall flag has dropped.
    task automatic sample(input logic [CHANNEL_W-1:0] ch, input logic [CONV_W-1:0] e);
        int n;
        stalled = 1'b0;
        recycled = 1'b0;
        loads = 0;
        n = 0;
        @(posedge clock);
        while (!pause_release_pulse) @(posedge clock);
        sample_instruction <= 1'b1;
        instruction_channel <= ch;
        do begin
            @(posedge clock);
            n++;
        end while (!(delayed_fifth_pulse && !fifth_time_state && !recycle_sync_flag
                     && !state_five_recycle_flag) && n < 3000);
        span_n = n;
        sample_instruction <= 1'b0;
        instruction_channel <= CHANNEL_W'($random(seed));
        @(posedge clock);
        chk("accumulator", to_acc(e), accumulator_data);
        chk("channel", ch, channel_select_register);
        chk("sample ends", 1, n < 3000);
    endtask : sample

    task automatic special(input logic sel, input logic pre);
        special_function_instruction <= 1'b1;
        fast_mode_select_bit <= sel;
        io_preset <= pre;
        @(posedge clock);
        special_function_instruction <= 1'b0;
        io_preset <= 1'b0;
        @(posedge clock);
    endtask : special

    always @(posedge clock) begin
        if (sample_instruction && fifth_time_state) stalled = 1'b1;
        if (sample_recycle_enable) recycled = 1'b1;
        if (accumulator_load) loads++;
        if (!conversion_busy_flag) begin
            settle_n = 0;
            hold_n = 0;
        end else if (conversion_start_pulse) begin
            chk("settle", ACC_W'(SETTLE_CYCLES), settle_n);
            chk("hold", ACC_W'(HOLD_CYCLES), hold_n);
        end else if (sample_hold_flag) begin
            hold_n++;
        end else begin
            settle_n++;
        end
    end

    initial begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end

    // About nine conversions of some 500 cycles each should finish well inside this.
    initial begin
        #1000000;
        fail_count++;
        close_out();
    end

    // ------------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------------
    initial begin
        {arst_n, io_preset, sample_instruction, special_function_instruction} = 4'h0;
        fast_mode_select_bit = 1'b0;
        instruction_channel = 5'h00;
        next_code = 10'h000;
        repeat (12) @(posedge clock);
        arst_n <= 1'b1;
        chk("pause reset", 1, sample_pause_flag);
        for (int i = 0; i < 6; i++) begin
            c = (i < 4) ? corner[i] : CONV_W'($random(seed));
            next_code <= c;
            sample((i == 1) ? 5'h0F : {1'b0, 4'($random(seed))}, c);
            chk("stalled", 1, stalled);
            chk("busy clear", 0, conversion_busy_flag);
            chk("pause again", 1, sample_pause_flag);
            chk("sample time", 1, span_n * CLOCK_PERIOD_NS > SAMPLE_TOTAL_NS * 9 / 10
                && span_n * CLOCK_PERIOD_NS < SAMPLE_TOTAL_NS * 11 / 10);
        end
        special(1'b1, 1'b0);
        chk("fast set", 1, early_readout_mode_flag);
        sample(5'h03, c);
        chk("fast no stall", 0, stalled | recycled);
        chk("fast loads", 1, loads);
        chk("fast busy", 1, conversion_busy_flag);
        c = CONV_W'($random(seed));
        next_code <= c;
        sample(5'h0A, c);
        chk("busy stall", 1, stalled);
        chk("restart", 1, conversion_busy_flag);
        chk("fast kept", 1, early_readout_mode_flag);
        c = CONV_W'($random(seed));
        next_code <= c;
        for (int n = 0; n < 2000 && conversion_busy_flag; n++) @(posedge clock);
        chk("busy ends", 0, conversion_busy_flag);
        // Waiting out the conversion keeps the spacing that a fast program must honour.
        sample(5'h05, c);
        chk("spaced no stall", 0, stalled | recycled);
        special(1'b0, 1'b0);
        chk("fast cleared", 0, early_readout_mode_flag);
        special(1'b1, 1'b1);
        chk("preset clears", 0, early_readout_mode_flag);
        chk("preset pause", 1, sample_pause_flag);
        close_out();
    end
endmodule : testbench
